// ---- bus_ecc_ctrl.v ----
// Bus controller ECC control, status, error logging and write check-bit path.
`timescale 1ns/1ns
`include "bus_ecc_defs.vh"
module bus_ecc_ctrl (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [3:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [31:0] reg_wdata_in,
  output reg  [31:0] reg_rdata_out,
  input  wire        pending_in,
  input  wire        rd_valid_in,
  input  wire [63:0] rd_data_in,
  input  wire [7:0]  rd_check_in,
  input  wire [31:0] xact_addr_in,
  input  wire        xact_is_read_in,
  input  wire        abort_in,
  output reg         rd_valid_out,
  output reg  [63:0] rd_data_out,
  output reg         rd_abort_out,
  input  wire [63:0] wr_data_in,
  output reg  [7:0]  check_bits_bus_out,
  input  wire        sub_width_write_in,
  output wire        rmw_needed_out,
  input  wire [31:0] fill_addr_in,
  output wire [31:0] fill_issue_addr_out,
  output wire        irq_out
);
  localparam [1:0] EN_IDLE = 2'b01;
  localparam [1:0] EN_WAIT = 2'b10;

  reg        overflow;
  reg        log1_valid;
  reg        log0_valid;
  reg        ecc_enable;
  reg        req_enable;
  reg [1:0]  en_state;
  reg        single_bit_correct_enable;
  reg        single_bit_report_enable;
  reg        critical_word_address_first;
  reg        write_ecc_disable;
  reg [7:0]  fault_mask;
  reg [31:0] error_log_0;
  reg [31:0] error_log_1;
  reg [31:0] error_address_0;
  reg [31:0] error_address_1;
  reg [63:0] pipe_data;
  reg [7:0]  pipe_check;
  reg [31:0] pipe_addr;
  reg        pipe_valid;
  reg        pipe_abort;
  reg        pipe_ecc;
  reg        burst_open;
  reg [31:0] burst_addr;
  reg        chk_valid;
  reg        chk_multi;
  reg [63:0] chk_data;

  wire [7:0]  gen_rd;
  wire [7:0]  syndrome;
  wire [63:0] corrected;
  wire        single_err;
  wire        multi_err;
  wire [7:0]  gen_wr;

  ecc_codec rd_codec (
    .data_in       (pipe_data),
    .check_in      (pipe_check),
    .gen_check_out (gen_rd),
    .syndrome_out  (syndrome),
    .corrected_out (corrected),
    .single_out    (single_err),
    .multi_out     (multi_err)
  );

  ecc_codec wr_codec (
    .data_in       (wr_data_in),
    .check_in      (8'h00),
    .gen_check_out (gen_wr),
    .syndrome_out  (),
    .corrected_out (),
    .single_out    (),
    .multi_out     ()
  );

  wire ctl_wr   = reg_wr_in && reg_addr_in == `REG_CONTROL;
  wire mode_wr  = reg_wr_in && reg_addr_in == `REG_MODE;
  wire fault_wr = reg_wr_in && reg_addr_in == `REG_FAULT;

  // Burst start address is held for the whole transaction so a late error logs the start.
  wire [31:0] cur_addr = burst_open ? burst_addr : xact_addr_in;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      burst_open <= 1'b0;
      burst_addr <= 32'h00000000;
    end else begin
      burst_open <= pending_in;
      if (!burst_open && pending_in) begin
        burst_addr <= xact_addr_in;
      end
    end
  end

  // First checking stage; a bus abort overrides ECC in its cycle.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      pipe_valid <= 1'b0;
      pipe_abort <= 1'b0;
      pipe_ecc   <= 1'b0;
      pipe_data  <= 64'h0000000000000000;
      pipe_check <= 8'h00;
      pipe_addr  <= 32'h00000000;
    end else begin
      pipe_valid <= rd_valid_in && ecc_enable && xact_is_read_in;
      pipe_abort <= abort_in;
      pipe_ecc   <= ecc_enable;
      pipe_data  <= rd_data_in;
      pipe_check <= rd_check_in;
      pipe_addr  <= cur_addr;
    end
  end

  wire ev_abort  = pipe_abort;
  wire ev_single = pipe_valid && pipe_ecc && !pipe_abort && single_err;
  wire ev_multi  = pipe_valid && pipe_ecc && !pipe_abort && multi_err;
  wire ev_any    = ev_abort | ev_single | ev_multi;

  // Second checking stage, so ECC reads arrive two cycles later than plain reads.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      chk_valid <= 1'b0;
      chk_multi <= 1'b0;
      chk_data  <= 64'h0000000000000000;
    end else begin
      chk_valid <= pipe_valid;
      chk_multi <= ev_multi;
      if (ev_single && single_bit_correct_enable) begin
        chk_data <= corrected;
      end else begin
        chk_data <= pipe_data;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 64'h0000000000000000;
      rd_abort_out <= 1'b0;
    end else begin
      if (ecc_enable) begin
        rd_valid_out <= chk_valid;
        rd_data_out  <= chk_data;
      end else begin
        rd_valid_out <= rd_valid_in;
        rd_data_out  <= rd_data_in;
      end
      rd_abort_out <= ev_abort | chk_multi;
    end
  end

  wire [31:0] log_word = {28'h0000000, 1'b0, ev_abort, ev_abort ? `LOG_TYPE_ABORT :
                          (ev_multi ? `LOG_TYPE_MULTI : `LOG_TYPE_SINGLE)};
  wire [31:0] log_addr = ev_abort ? pipe_addr : {pipe_addr[31:3], 3'h0};
  wire        take0    = ev_any && !log0_valid;
  wire        take1    = ev_any && log0_valid && !log1_valid;
  wire        take_ovf = ev_any && log0_valid && log1_valid;

  // Log registers are written only while free; the valid bit rises with the write.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      error_log_0     <= 32'h00000000;
      error_log_1     <= 32'h00000000;
      error_address_0 <= 32'h00000000;
      error_address_1 <= 32'h00000000;
    end else begin
      if (take0) begin
        error_log_0     <= log_word;
        error_address_0 <= log_addr;
      end
      if (take1) begin
        error_log_1     <= log_word;
        error_address_1 <= log_addr;
      end
    end
  end

  // Sticky flags: a hardware set outranks a write-one clear in the same cycle.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      overflow   <= 1'b0;
      log1_valid <= 1'b0;
      log0_valid <= 1'b0;
    end else begin
      if (take_ovf) begin
        overflow <= 1'b1;
      end else if (ctl_wr && reg_wdata_in[`CTL_OVERFLOW]) begin
        overflow <= 1'b0;
      end
      if (take1) begin
        log1_valid <= 1'b1;
      end else if (ctl_wr && reg_wdata_in[`CTL_LOG1_VALID]) begin
        log1_valid <= 1'b0;
      end
      if (take0) begin
        log0_valid <= 1'b1;
      end else if (ctl_wr && reg_wdata_in[`CTL_LOG0_VALID]) begin
        log0_valid <= 1'b0;
      end
    end
  end

  // The requested enable waits here until the bus controller has gone idle.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ecc_enable                <= 1'b0;
      req_enable                <= 1'b0;
      en_state                  <= EN_IDLE;
      single_bit_correct_enable <= 1'b0;
      single_bit_report_enable  <= 1'b0;
    end else begin
      if (ctl_wr) begin
        req_enable                <= reg_wdata_in[`CTL_ECC_ENABLE];
        single_bit_correct_enable <= reg_wdata_in[`CTL_CORRECT];
        single_bit_report_enable  <= reg_wdata_in[`CTL_REPORT];
      end
      case (en_state)
        EN_IDLE: begin
          if (ctl_wr && reg_wdata_in[`CTL_ECC_ENABLE] != ecc_enable) begin
            en_state <= EN_WAIT;
          end
        end
        EN_WAIT: begin
          if (!pending_in) begin
            ecc_enable <= req_enable;
            en_state   <= EN_IDLE;
          end
        end
        default: begin
          en_state <= EN_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      critical_word_address_first <= 1'b0;
      write_ecc_disable           <= 1'b0;
      fault_mask                  <= 8'h00;
    end else begin
      if (mode_wr) begin
        critical_word_address_first <= reg_wdata_in[`MODE_CRIT_FIRST];
      end
      if (fault_wr) begin
        write_ecc_disable <= reg_wdata_in[`FAULT_WDIS];
        fault_mask        <= reg_wdata_in[7:0];
      end
    end
  end

  // Write check bits: zero with ECC off, generated bits unmasked with write ECC disable, test mask inverts them otherwise.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      check_bits_bus_out <= 8'h00;
    end else if (!ecc_enable) begin
      check_bits_bus_out <= 8'h00;
    end else if (write_ecc_disable) begin
      check_bits_bus_out <= gen_wr;
    end else begin
      check_bits_bus_out <= gen_wr ^ fault_mask;
    end
  end

  assign rmw_needed_out = ecc_enable && !write_ecc_disable && sub_width_write_in;

  assign fill_issue_addr_out = critical_word_address_first ? fill_addr_in :
                               {fill_addr_in[31:5], 5'h00};

  // Every error sets a flag; the line itself is gated by ECC enable and the reporting bit.
  assign irq_out = ecc_enable && single_bit_report_enable &&
                   (overflow | log1_valid | log0_valid);

  always @* begin
    case (reg_addr_in)
      `REG_CONTROL: reg_rdata_out = {pending_in, overflow, log1_valid, log0_valid,
                                     24'h000000, ecc_enable, single_bit_correct_enable,
                                     1'b0, single_bit_report_enable};
      `REG_MODE:    reg_rdata_out = {31'h00000000, critical_word_address_first};
      `REG_LOG0:    reg_rdata_out = error_log_0;
      `REG_LOG1:    reg_rdata_out = error_log_1;
      `REG_ADDR0:   reg_rdata_out = error_address_0;
      `REG_ADDR1:   reg_rdata_out = error_address_1;
      `REG_FAULT:   reg_rdata_out = {24'h000000, fault_mask};
      default:      reg_rdata_out = 32'h00000000;
    endcase
  end
endmodule

// ---- bus_ecc_defs.vh ----
// Register map, field positions, reset values and timing counts of the bus ECC control block.
// Function
// - Control bit 31 reads 1 while transactions pend, 0 when idle; writes ignored.
// - Control bit 30 sets on error with both log pairs full; write 1 clears.
// - Bits 29 and 28 mark log pair one and zero valid; write 1 clears.
// - Reset clears every implemented control bit: ECC off, no log pair valid; the code leaves bit 31 reading pending_in.
// - A new ECC enable value takes effect only after pending operations complete.
// - With ECC on, single-bit errors interrupt only when single-bit reporting is set.
// - With ECC on, every multi-bit error raises an abort regardless of reporting.
// - Single-bit errors in read data are corrected only when correction is enabled.
// - With ECC off, received check bits are ignored and written check bits are zero.
// - ECC checking adds two memory clock cycles of read latency.
// - With reporting on, interrupt is asserted while any overflow or valid bit is set; the code also requires ECC on.
// - A valid log pair's log and address registers are never modified.
// - On error, fill a free log pair first, then set its valid bit.
// - Address register captures failing physical address, burst start address only.
// - ECC error addresses have bits 2 to 0 zero; bus aborts keep all bits.
// - Line fill issues aligned address when fill-order bit is 0, critical word if 1.
// - Each set test mask bit inverts that check bit in all generated write codes; the code skips the mask while write ECC disable is set.
// - Write ECC disable skips read-modify-write; driven check bits still match driven data.
// - Write ECC disable resets to zero, is write-only, and leaves reads unaffected.
// - Each 64-bit word has eight check bits: correct single, detect double errors.
// - Fill log pair zero first, then pair one, overflow flag when both in use.
`ifndef BUS_ECC_DEFS_VH
`define BUS_ECC_DEFS_VH
`define REG_CONTROL        4'h0
`define REG_MODE           4'h1
`define REG_LOG0           4'h4
`define REG_LOG1           4'h5
`define REG_ADDR0          4'h6
`define REG_ADDR1          4'h7
`define REG_FAULT          4'h8
`define CTL_PENDING        31
`define CTL_OVERFLOW       30
`define CTL_LOG1_VALID     29
`define CTL_LOG0_VALID     28
`define CTL_ECC_ENABLE     3
`define CTL_CORRECT        2
`define CTL_REPORT         0
`define MODE_CRIT_FIRST    0
`define FAULT_WDIS         31
`define CONTROL_RESET      32'h00000000
`define ECC_LATENCY_CYCLES 2
`define LOG_TYPE_ABORT     2'h1
`define LOG_TYPE_SINGLE    2'h2
`define LOG_TYPE_MULTI     2'h3
`endif

// ---- ecc_codec.v ----
// Eight-bit SEC-DED code over a 64-bit word: generation and syndrome decode.
`timescale 1ns/1ns
`include "bus_ecc_defs.vh"
module ecc_codec (
  input  wire [63:0] data_in,
  input  wire [7:0]  check_in,
  output wire [7:0]  gen_check_out,
  output wire [7:0]  syndrome_out,
  output wire [63:0] corrected_out,
  output wire        single_out,
  output wire        multi_out
);
  // Data bit i lives at the i-th Hamming position that is not a power of two.
  function [6:0] data_pos;
    input integer idx;
    integer p;
    integer n;
    begin
      data_pos = 7'h00;
      n = 0;
      for (p = 3; p < 72; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (n == idx) begin
            data_pos = p[6:0];
          end
          n = n + 1;
        end
      end
    end
  endfunction

  function [7:0] encode;
    input [63:0] d;
    integer i;
    integer b;
    reg [6:0] pos;
    begin
      encode = 8'h00;
      for (i = 0; i < 64; i = i + 1) begin
        pos = data_pos(i);
        for (b = 0; b < 7; b = b + 1) begin
          if (pos[b]) begin
            encode[b] = encode[b] ^ d[i];
          end
        end
      end
      encode[7] = ^{d, encode[6:0]};
    end
  endfunction

  reg [63:0] flip;
  integer    k;

  assign gen_check_out = encode(data_in);
  // The top syndrome bit is the parity of every received bit, so it flags odd error counts.
  assign syndrome_out  = {^{data_in, check_in}, gen_check_out[6:0] ^ check_in[6:0]};
  assign single_out    = syndrome_out[7];
  assign multi_out     = ~syndrome_out[7] & (syndrome_out[6:0] != 7'h00);

  always @* begin
    flip = 64'h0000000000000000;
    for (k = 0; k < 64; k = k + 1) begin
      if (single_out && syndrome_out[6:0] == data_pos(k)) begin
        flip[k] = 1'b1;
      end
    end
  end

  assign corrected_out = data_in ^ flip;
endmodule

// ---- bus_ecc_ctrl_chk.sv ----
// Port-level assertions for the bus ECC control block.
`timescale 1ns/1ns
module bus_ecc_ctrl_chk (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire [3:0]  reg_addr_in,
  input wire        reg_wr_in,
  input wire [31:0] reg_rdata_out,
  input wire        pending_in,
  input wire        rd_valid_in,
  input wire        rd_valid_out,
  input wire        sub_width_write_in,
  input wire        rmw_needed_out,
  input wire [31:0] fill_addr_in,
  input wire [31:0] fill_issue_addr_out,
  input wire        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_busy;
    reg_addr_in == 4'h0 |-> reg_rdata_out[31] == pending_in;
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit differs from pending");
  property p_lat;
    rd_valid_out |-> $past(rd_valid_in) || $past(rd_valid_in, 3);
  endproperty
  a_lat: assert property (p_lat) else $error("read result without beat");
  property p_irq;
    irq_out && reg_addr_in == 4'h0 |-> reg_rdata_out[30:28] != 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt with no flag");
  property p_fill_hi;
    fill_issue_addr_out[31:5] == fill_addr_in[31:5];
  endproperty
  a_fill_hi: assert property (p_fill_hi) else $error("fill line address wrong");
  property p_fill_lo;
    fill_issue_addr_out[4:0] == 5'h00 || fill_issue_addr_out[4:0] == fill_addr_in[4:0];
  endproperty
  a_fill_lo: assert property (p_fill_lo) else $error("fill word offset wrong");
  property p_rmw;
    rmw_needed_out |-> sub_width_write_in;
  endproperty
  a_rmw: assert property (p_rmw) else $error("merge cycle for full write");
  property p_irq_fall;
    $fell(irq_out) |-> $past(reg_wr_in) || !$past(pending_in);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
  property p_rst;
    $past(sys_rst_in) && reg_addr_in == 4'h0 |-> (reg_rdata_out & 32'h7000000F) == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("control not cleared by reset");
  c_valid: cover property (rd_valid_out);
  c_irq: cover property ($fell(irq_out));
  c_rmw: cover property (rmw_needed_out);
endmodule

// ---- mem_model.sv ----
// External memory model holding one word with its check bits, answering with read beats.
`timescale 1ns/1ns
module mem_model (
  input  wire        clk_in,
  input  wire        store_in,
  input  wire        send_in,
  input  wire [63:0] flip_in,
  input  wire [63:0] wr_data_in,
  input  wire [7:0]  check_in,
  output reg         beat_out,
  output reg  [63:0] data_out,
  output reg  [7:0]  check_out
);
  reg [63:0] mem = 64'h0;
  reg [7:0]  mem_chk = 8'h00;
  initial beat_out = 1'b0;
  initial data_out = 64'h0;
  initial check_out = 8'h00;
  // Between beats the lines toggle so stale data is never mistaken for a beat.
  always @(posedge clk_in) begin
    if (store_in) begin
      mem <= wr_data_in;
      mem_chk <= check_in;
    end
    beat_out <= send_in;
    data_out <= send_in ? mem ^ flip_in : ~data_out;
    check_out <= send_in ? mem_chk : ~check_out;
  end
endmodule

// ---- test_bus_ecc_ctrl.sv ----
// Self-checking test of the bus ECC control block against a memory model.
`timescale 1ns/1ns
`include "bus_ecc_defs.vh"
module test_bus_ecc_ctrl;
  localparam [63:0] D = 64'h0123456789ABCDEF;
  localparam [31:0] A = 32'h8000104C;
  reg         clk_in = 1'b0;
  reg         sys_rst_in = 1'b1;
  reg  [3:0]  reg_addr_in = 4'h0;
  reg         reg_wr_in = 1'b0;
  reg  [31:0] reg_wdata_in = 32'h0;
  reg         pending_in = 1'b1;
  reg  [31:0] xact_addr_in = A;
  reg         abort_in = 1'b0;
  reg  [63:0] wr_data_in = 64'h0;
  reg         sub_width_write_in = 1'b0;
  reg  [31:0] fill_addr_in = 32'h80001234;
  reg         send = 1'b0;
  reg         store = 1'b0;
  reg  [63:0] flip = 64'h0;
  wire        rd_valid_in, rd_valid_out, rd_abort_out, rmw_needed_out, irq_out;
  wire [63:0] rd_data_in, rd_data_out;
  wire [7:0]  rd_check_in, check_bits_bus_out;
  wire [31:0] reg_rdata_out, fill_issue_addr_out;
  reg  [63:0] got_d;
  reg  [7:0]  c0, c1;
  integer     miscompares = 0;
  integer     tests_run = 0;
  always #10 clk_in = ~clk_in;
  bus_ecc_ctrl DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(1'b0), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .pending_in(pending_in), .rd_valid_in(rd_valid_in),
    .rd_data_in(rd_data_in), .rd_check_in(rd_check_in), .xact_addr_in(xact_addr_in),
    .xact_is_read_in(1'b1), .abort_in(abort_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .rd_abort_out(rd_abort_out), .wr_data_in(wr_data_in),
    .check_bits_bus_out(check_bits_bus_out), .sub_width_write_in(sub_width_write_in),
    .rmw_needed_out(rmw_needed_out), .fill_addr_in(fill_addr_in),
    .fill_issue_addr_out(fill_issue_addr_out), .irq_out(irq_out));
  mem_model mem (.clk_in(clk_in), .store_in(store), .send_in(send), .flip_in(flip),
    .wr_data_in(wr_data_in), .check_in(check_bits_bus_out), .beat_out(rd_valid_in),
    .data_out(rd_data_in), .check_out(rd_check_in));
  task results;
    begin
      $display("%0d comparisons, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp(input [63:0] g, input [63:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_in) begin
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
      end
      @(posedge clk_in) reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk_in) reg_addr_in <= a;
      @(negedge clk_in) cmp({32'h0, reg_rdata_out & m}, {32'h0, e});
    end
  endtask
  task put(input [63:0] d, output [7:0] c);
    begin
      @(posedge clk_in) wr_data_in <= d;
      @(posedge clk_in) store <= 1'b1;
      @(negedge clk_in) c = check_bits_bus_out;
      @(posedge clk_in) store <= 1'b0;
    end
  endtask
  // Counts clock cycles from the send request to the read result; lat is the ECC delay.
  task beat(input [31:0] a, input [63:0] f, input integer lat);
    integer n;
    begin
      @(posedge clk_in) begin
        xact_addr_in <= a;
        flip <= f;
        send <= 1'b1;
      end
      @(posedge clk_in) send <= 1'b0;
      n = 1;
      while (rd_valid_out !== 1'b1 && n < 9) begin
        @(negedge clk_in);
        n = n + 1;
      end
      got_d = rd_data_out;
      cmp(n, 3 + lat);
    end
  endtask
  task abt(input [31:0] a);
    begin
      @(posedge clk_in) begin
        xact_addr_in <= a;
        abort_in <= 1'b1;
      end
      @(posedge clk_in) abort_in <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
  initial begin
    #(20 * 3000);
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(4'h0, 32'h7000000F, 32'h0);
    wr(4'h0, 32'h80000000);
    rd(4'h0, 32'h80000000, 32'h80000000);
    put(D, c0);
    cmp(c0, 8'h00);
    beat(A, 64'h3, 0);
    cmp(got_d, D ^ 64'h3);
    wr(4'h0, 32'h0000000D);
    beat(A, 64'h0, 0);
    $display("test ecc off done");
    @(posedge clk_in) pending_in <= 1'b0;
    rd(4'h0, 32'h80000000, 32'h0);
    put(D, c0);
    wr(4'h8, 32'h000000A5);
    put(D, c1);
    cmp(c0 ^ c1, 8'hA5);
    wr(4'h8, 32'h0);
    put(D, c0);
    beat(A, 64'h0, `ECC_LATENCY_CYCLES);
    rd(4'h0, 32'h70000000, 32'h0);
    beat(A, 64'h20, `ECC_LATENCY_CYCLES);
    cmp(got_d, D);
    rd(4'h0, 32'h70000000, 32'h10000000);
    rd(4'h6, 32'hFFFFFFFF, A & 32'hFFFFFFF8);
    rd(4'h4, 32'h7, 32'h2);
    cmp(irq_out, 1'b1);
    beat(32'h80002000, 64'h300, `ECC_LATENCY_CYCLES);
    cmp(rd_abort_out, 1'b1);
    rd(4'h0, 32'h70000000, 32'h30000000);
    rd(4'h7, 32'hFFFFFFFF, 32'h80002000);
    rd(4'h6, 32'hFFFFFFFF, A & 32'hFFFFFFF8);
    abt(32'h80001053);
    rd(4'h0, 32'h70000000, 32'h70000000);
    $display("test logging done");
    wr(4'h0, 32'h1000000D);
    rd(4'h0, 32'h70000000, 32'h60000000);
    cmp(irq_out, 1'b1);
    wr(4'h0, 32'h6000000D);
    rd(4'h0, 32'h70000000, 32'h0);
    cmp(irq_out, 1'b0);
    abt(32'h80001053);
    rd(4'h6, 32'hFFFFFFFF, 32'h80001053);
    rd(4'h4, 32'h7, 32'h5);
    $display("test clearing done");
    wr(4'h0, 32'h10000005);
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h00000008);
    beat(A, 64'h20, `ECC_LATENCY_CYCLES);
    cmp(got_d, D ^ 64'h20);
    cmp(irq_out, 1'b0);
    @(posedge clk_in) sub_width_write_in <= 1'b1;
    @(negedge clk_in) cmp(rmw_needed_out, 1'b1);
    wr(4'h0, 32'h10000000);
    wr(4'h0, 32'h0);
    wr(4'h8, 32'h80000000);
    wr(4'h0, 32'h00000008);
    repeat (2) @(negedge clk_in);
    cmp(rmw_needed_out, 1'b0);
    beat(A, 64'h0, `ECC_LATENCY_CYCLES);
    cmp(got_d, D);
    $display("test write disable done");
    wr(4'h1, 32'h0);
    @(negedge clk_in) cmp(fill_issue_addr_out, 32'h80001220);
    wr(4'h1, 32'h1);
    @(negedge clk_in) cmp(fill_issue_addr_out, 32'h80001234);
    $display("test fill order done");
    results;
  end
endmodule
bind bus_ecc_ctrl bus_ecc_ctrl_chk chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
  .pending_in(pending_in), .rd_valid_in(rd_valid_in), .rd_valid_out(rd_valid_out),
  .sub_width_write_in(sub_width_write_in), .rmw_needed_out(rmw_needed_out),
  .fill_addr_in(fill_addr_in), .fill_issue_addr_out(fill_issue_addr_out), .irq_out(irq_out));
